// File: design/sarc_consts.svh
`ifndef SARC_CONSTS_SVH
`define SARC_CONSTS_SVH

// ==========================================================
// Clock
`define SARC_CLK_NS 10

// ==========================================================
// Result layout
`define SARC_RES_W 12
`define SARC_BYTE_W 8
`define SARC_NIB_W 4
`define SARC_IDX_W 4
`define SARC_MSB_IDX 4'hB
`define SARC_SHORT_LAST_IDX 4'h4
`define SARC_FULL_LAST_IDX 4'h0
`define SARC_FULL_BITS 12
`define SARC_SHORT_BITS 8

// ==========================================================
// Conversion timing
`define SARC_FULL_MAX_NS 35000
`define SARC_SHORT_MAX_NS 24000
`define SARC_BIT_STEP_NS 2000
`define SARC_BIT_STEP_CYC (`SARC_BIT_STEP_NS / `SARC_CLK_NS)

// ==========================================================
// Host pin timing, least times rounded up
`define SARC_SETUP_NS 300
`define SARC_SETUP_CYC \
  ((`SARC_SETUP_NS + `SARC_CLK_NS - 1) / `SARC_CLK_NS)
`define SARC_CE_PULSE_NS 300
`define SARC_CE_PULSE_CYC \
  ((`SARC_CE_PULSE_NS + `SARC_CLK_NS - 1) / `SARC_CLK_NS)
`define SARC_TMR_W 6

// ==========================================================
// Host register map
`define SARC_APB_AW 8
`define SARC_OFS_CMD 8'h00
`define SARC_OFS_CFG 8'h04
`define SARC_OFS_STAT 8'h08
`define SARC_OFS_RESULT 8'h0C
`define SARC_OFS_IRQ_STAT 8'h10
`define SARC_OFS_IRQ_MASK 8'h14
`define SARC_CMD_START_BIT 0
`define SARC_CMD_SHORT_BIT 1
`define SARC_CMD_READ_BIT 2
`define SARC_CFG_WORD_BIT 0
`define SARC_STAT_BUSY_BIT 0
`define SARC_STAT_HOST_BIT 1
`define SARC_IRQ_W 2
`define SARC_IRQ_CONV_BIT 0
`define SARC_IRQ_READ_BIT 1

`endif

// File: design/sarc_pkg.sv
`include "sarc_consts.svh"

package sarc_pkg;
  typedef logic [`SARC_RES_W-1:0] sarc_word_t;
  typedef enum logic {SD_IDLE, SD_CONV} sarc_dev_state_t;
  typedef enum logic [1:0] {SH_IDLE, SH_SETUP, SH_PULSE, SH_WAIT}
    sarc_host_state_t;
endpackage

// File: design/sarc_bus_if.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Converter bus between host controller and converter
interface sarc_bus_if;
  logic chip_en;
  logic sel_n;
  logic read_conv;
  logic byte_address_line;
  logic word_width_sel;
  sarc_pkg::sarc_word_t data;
  logic data_hi_oe;
  logic data_lo_oe;
  logic conversion_busy_flag;

  modport dev (
    input chip_en, sel_n, read_conv, byte_address_line, word_width_sel,
    output data, data_hi_oe, data_lo_oe, conversion_busy_flag
  );

  modport host (
    output chip_en, sel_n, read_conv, byte_address_line, word_width_sel,
    input data, data_hi_oe, data_lo_oe, conversion_busy_flag
  );
endinterface

`default_nettype wire

// File: design/sarc_dev.sv
// Notes on behaviour
// - No action unless enabled and selected.
// - Read/convert high reads, low starts conversion.
// - Byte address low full cycle, high short.
// - Byte mode: address selects high or low part.
// - Width select high gives whole word.
// - Odd byte: low nibble high, zeros below.
// - Host keeps width select static.
// - Host holds byte address through a read.
// - Start clears done flags; set per length.
// - Data outputs off during conversion.
// - Busy flag high throughout conversion.
// - Starts ignored while conversion runs.
// - Host sets convert before enabling.
// - Host may enable last with either.
// - Start clears result register, runs stepping.
// - Trial bits MSB first, kept if not over.
`timescale 1ns/100ps
`default_nettype none

`include "sarc_consts.svh"

module sarc_dev #(
  parameter int BIT_STEP_CYC = `SARC_BIT_STEP_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Converter bus
  sarc_bus_if.dev bus,
  // Comparator and trial code
  input wire logic cmp_le_i,
  output sarc_pkg::sarc_word_t trial_code_o,
  // End-of-cycle flags
  output logic short_cycle_done_o,
  output logic full_cycle_done_o
);
  import sarc_pkg::*;

  // ========================================================
  // Elaboration checks
  localparam int FULL_NS = BIT_STEP_CYC * `SARC_CLK_NS * `SARC_FULL_BITS;
  localparam int SHORT_NS =
    BIT_STEP_CYC * `SARC_CLK_NS * `SARC_SHORT_BITS;

  // Trial code is registered, so a step needs a cycle to settle
  if (BIT_STEP_CYC < 2)
  begin : g_step_min
    $error("step count must be at least two cycles");
  end
  if (FULL_NS > `SARC_FULL_MAX_NS || SHORT_NS > `SARC_SHORT_MAX_NS)
  begin : g_step_max
    $error("step count too long for conversion time");
  end

  localparam int STEP_W = (BIT_STEP_CYC > 1) ? $clog2(BIT_STEP_CYC) : 1;
  localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(BIT_STEP_CYC - 1);

  // ========================================================
  // Bus decode
  logic selected;
  logic start_req;
  logic read_req;
  logic start_req_q;
  logic start_edge;
  sarc_dev_state_t state;
  logic busy;

  assign selected = bus.chip_en & ~bus.sel_n;
  assign start_req = selected & ~bus.read_conv;
  assign read_req = selected & bus.read_conv & ~busy;
  assign start_edge = start_req & ~start_req_q;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      start_req_q <= 1'b0;
    else if (ce_i)
      start_req_q <= start_req;
  end

  // ========================================================
  // Conversion sequencing
  logic [`SARC_IDX_W-1:0] bit_idx;
  logic [`SARC_IDX_W-1:0] last_idx;
  logic [STEP_W-1:0] step_cnt;
  logic short_mode;
  logic step_end;
  sarc_word_t sar;

  assign busy = (state == SD_CONV);
  assign step_end = busy && (step_cnt == STEP_LAST);
  assign last_idx = short_mode ? `SARC_SHORT_LAST_IDX
                               : `SARC_FULL_LAST_IDX;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state <= SD_IDLE;
    else if (ce_i)
    begin
      case (state)
        SD_IDLE:
          if (start_edge)
            state <= SD_CONV;
        SD_CONV:
          // Further starts are not looked at here
          if (step_end && bit_idx == last_idx)
            state <= SD_IDLE;
        default:
          state <= SD_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      short_mode <= 1'b0;
    else if (ce_i && !busy && start_edge)
      short_mode <= bus.byte_address_line;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      step_cnt <= '0;
      bit_idx <= `SARC_MSB_IDX;
    end
    else if (ce_i)
    begin
      if (!busy && start_edge)
      begin
        step_cnt <= '0;
        bit_idx <= `SARC_MSB_IDX;
      end
      else if (step_end)
      begin
        step_cnt <= '0;
        if (bit_idx != last_idx)
        begin
          bit_idx <= bit_idx - `SARC_IDX_W'(1);
        end
      end
      else if (busy)
      begin
        step_cnt <= step_cnt + STEP_W'(1);
      end
    end
  end

  // ========================================================
  // Successive-approximation register
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      sar <= '0;
    else if (ce_i)
    begin
      if (!busy && start_edge)
        sar <= '0;
      else if (step_end)
        sar[bit_idx] <= cmp_le_i;
    end
  end

  // Trial code is the kept bits plus the bit under test
  sarc_word_t next_trial;

  always_comb
  begin
    next_trial = sar;
    if (busy)
    begin
      next_trial[bit_idx] = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      trial_code_o <= '0;
    else if (ce_i)
      trial_code_o <= next_trial;
  end

  // ========================================================
  // End-of-cycle flags and busy output
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      short_cycle_done_o <= 1'b1;
      full_cycle_done_o <= 1'b1;
    end
    else if (ce_i)
    begin
      if (!busy && start_edge)
      begin
        short_cycle_done_o <= 1'b0;
        full_cycle_done_o <= 1'b0;
      end
      else if (step_end)
      begin
        if (bit_idx == `SARC_SHORT_LAST_IDX)
        begin
          short_cycle_done_o <= 1'b1;
        end
        if (bit_idx == last_idx)
        begin
          full_cycle_done_o <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      bus.conversion_busy_flag <= 1'b0;
    else if (ce_i)
      bus.conversion_busy_flag <= busy | start_edge;
  end

  // ========================================================
  // Output buffers
  sarc_word_t next_data;
  logic next_hi_oe;
  logic next_lo_oe;

  always_comb
  begin
    next_data = sar;
    next_hi_oe = read_req;
    next_lo_oe = read_req;
    if (!bus.word_width_sel)
    begin
      next_lo_oe = 1'b0;
      if (!bus.byte_address_line)
        next_data = {sar[`SARC_RES_W-1 -: `SARC_BYTE_W],
                     `SARC_NIB_W'(0)};
      else
        next_data = {sar[`SARC_NIB_W-1:0],
                     `SARC_BYTE_W'(0)};
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      bus.data <= '0;
      bus.data_hi_oe <= 1'b0;
      bus.data_lo_oe <= 1'b0;
    end
    else if (ce_i)
    begin
      bus.data <= next_data;
      bus.data_hi_oe <= next_hi_oe;
      bus.data_lo_oe <= next_lo_oe;
    end
  end

endmodule

`default_nettype wire

// File: design/sarc_host.sv
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

`include "sarc_consts.svh"

module sarc_host (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`SARC_APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt
  output logic irq_o,
  // Converter bus
  sarc_bus_if.host bus
);
  import sarc_pkg::*;

  localparam logic [`SARC_TMR_W-1:0] SETUP_LAST =
    `SARC_TMR_W'(`SARC_SETUP_CYC - 1);
  localparam logic [`SARC_TMR_W-1:0] PULSE_LAST =
    `SARC_TMR_W'(`SARC_CE_PULSE_CYC - 1);

  // ========================================================
  // APB decode
  logic wr_acc;
  logic mapped;
  logic cmd_wr;
  sarc_host_state_t state;
  logic [`SARC_TMR_W-1:0] tmr;
  logic is_read;
  logic word_mode;
  sarc_word_t result;
  logic [`SARC_IRQ_W-1:0] irq_stat;
  logic [`SARC_IRQ_W-1:0] irq_mask;
  logic [`SARC_IRQ_W-1:0] irq_set;

  assign wr_acc = psel & penable & pwrite;
  // No wait states, but hold the access while frozen
  assign pready = ce_i;
  assign cmd_wr = wr_acc && paddr == `SARC_OFS_CMD;

  always_comb
  begin
    if (paddr == `SARC_OFS_CMD)
      mapped = 1'b1;
    else if (paddr == `SARC_OFS_CFG)
      mapped = 1'b1;
    else if (paddr == `SARC_OFS_STAT)
      mapped = 1'b1;
    else if (paddr == `SARC_OFS_RESULT)
      mapped = 1'b1;
    else if (paddr == `SARC_OFS_IRQ_STAT)
      mapped = 1'b1;
    else if (paddr == `SARC_OFS_IRQ_MASK)
      mapped = 1'b1;
    else
      mapped = 1'b0;
  end

  assign pslverr = psel & penable & ~mapped;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      prdata <= '0;
    else if (ce_i && psel && !penable)
    begin
      prdata <= '0;
      if (paddr == `SARC_OFS_CFG)
        prdata[`SARC_CFG_WORD_BIT] <= word_mode;
      else if (paddr == `SARC_OFS_STAT)
      begin
        prdata[`SARC_STAT_BUSY_BIT] <= bus.conversion_busy_flag;
        prdata[`SARC_STAT_HOST_BIT] <= (state != SH_IDLE);
      end
      else if (paddr == `SARC_OFS_RESULT)
        prdata[`SARC_RES_W-1:0] <= result;
      else if (paddr == `SARC_OFS_IRQ_STAT)
        prdata[`SARC_IRQ_W-1:0] <= irq_stat;
      else if (paddr == `SARC_OFS_IRQ_MASK)
        prdata[`SARC_IRQ_W-1:0] <= irq_mask;
    end
  end

  // ========================================================
  // Configuration, changed only while idle
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      word_mode <= 1'b1;
    else if (ce_i && wr_acc && paddr == `SARC_OFS_CFG
             && state == SH_IDLE)
      word_mode <= pwdata[`SARC_CFG_WORD_BIT];
  end

  assign bus.word_width_sel = word_mode;

  // ========================================================
  // Bus sequencer
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state <= SH_IDLE;
      tmr <= '0;
      is_read <= 1'b0;
      bus.chip_en <= 1'b0;
      bus.sel_n <= 1'b1;
      bus.read_conv <= 1'b1;
      bus.byte_address_line <= 1'b0;
      result <= '0;
    end
    else if (ce_i)
    begin
      case (state)
        SH_IDLE:
        begin
          tmr <= '0;
          if (cmd_wr && pwdata[`SARC_CMD_READ_BIT])
          begin
            is_read <= 1'b1;
            bus.sel_n <= 1'b0;
            bus.read_conv <= 1'b1;
            bus.byte_address_line <= 1'b0;
            state <= SH_SETUP;
          end
          else if (cmd_wr && pwdata[`SARC_CMD_START_BIT]
                   && !bus.conversion_busy_flag)
          begin
            is_read <= 1'b0;
            bus.sel_n <= 1'b0;
            bus.read_conv <= 1'b0;
            bus.byte_address_line <= pwdata[`SARC_CMD_SHORT_BIT];
            state <= SH_SETUP;
          end
        end
        SH_SETUP:
        begin
          tmr <= tmr + `SARC_TMR_W'(1);
          if (tmr == SETUP_LAST)
          begin
            tmr <= '0;
            bus.chip_en <= 1'b1;
            state <= SH_PULSE;
          end
        end
        SH_PULSE:
        begin
          tmr <= tmr + `SARC_TMR_W'(1);
          if (tmr == PULSE_LAST)
          begin
            tmr <= '0;
            bus.chip_en <= 1'b0;
            if (!is_read)
            begin
              bus.sel_n <= 1'b1;
              state <= SH_WAIT;
            end
            else if (word_mode)
            begin
              result <= bus.data;
              bus.sel_n <= 1'b1;
              state <= SH_IDLE;
            end
            else if (!bus.byte_address_line)
            begin
              result[`SARC_RES_W-1 -: `SARC_BYTE_W] <=
                bus.data[`SARC_RES_W-1 -: `SARC_BYTE_W];
              bus.byte_address_line <= 1'b1;
              state <= SH_SETUP;
            end
            else
            begin
              result[`SARC_NIB_W-1:0] <=
                bus.data[`SARC_RES_W-1 -: `SARC_NIB_W];
              bus.sel_n <= 1'b1;
              bus.byte_address_line <= 1'b0;
              state <= SH_IDLE;
            end
          end
        end
        SH_WAIT:
        begin
          if (!bus.conversion_busy_flag)
          begin
            bus.read_conv <= 1'b1;
            state <= SH_IDLE;
          end
        end
        default:
        begin
          state <= SH_IDLE;
        end
      endcase
    end
  end

  // ========================================================
  // Interrupts
  always_comb
  begin
    irq_set = '0;
    irq_set[`SARC_IRQ_CONV_BIT] =
      (state == SH_WAIT) && !bus.conversion_busy_flag;
    irq_set[`SARC_IRQ_READ_BIT] = (state == SH_PULSE) && is_read
      && tmr == PULSE_LAST && (word_mode || bus.byte_address_line);
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      irq_stat <= '0;
      irq_mask <= '0;
    end
    else if (ce_i)
    begin
      if (wr_acc && paddr == `SARC_OFS_IRQ_STAT)
        irq_stat <= (irq_stat & ~pwdata[`SARC_IRQ_W-1:0]) | irq_set;
      else
        irq_stat <= irq_stat | irq_set;
      if (wr_acc && paddr == `SARC_OFS_IRQ_MASK)
        irq_mask <= pwdata[`SARC_IRQ_W-1:0];
    end
  end

  assign irq_o = |(irq_stat & irq_mask);

endmodule

`default_nettype wire

// File: testbench/sarc_bus_asserts.sv
`timescale 1ns/100ps
`default_nettype none

`include "sarc_consts.svh"

module sarc_bus_asserts #(
  parameter int BIT_STEP_CYC = `SARC_BIT_STEP_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Converter bus
  input wire logic chip_en,
  input wire logic sel_n,
  input wire logic read_conv,
  input wire logic byte_address_line,
  input wire logic word_width_sel,
  input wire sarc_pkg::sarc_word_t data,
  input wire logic data_hi_oe,
  input wire logic data_lo_oe,
  input wire logic conversion_busy_flag,
  // End-of-cycle flags
  input wire logic short_cycle_done,
  input wire logic full_cycle_done
);
  import sarc_pkg::*;
  localparam int FULL_CYC = `SARC_FULL_BITS * BIT_STEP_CYC;
  localparam int SHORT_CYC = `SARC_SHORT_BITS * BIT_STEP_CYC;
  logic conv_req;
  logic conv_req_q;
  logic short_run;
  int busy_cnt;
  int need;

  // ==========================================================
  // Helper logic
  assign conv_req = chip_en && !sel_n && !read_conv;
  assign need = short_run ? SHORT_CYC : FULL_CYC;
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      conv_req_q <= 1'b0;
      short_run <= 1'b0;
      busy_cnt <= 0;
    end
    else
    begin
      conv_req_q <= conv_req;
      if (conv_req && !conv_req_q && !conversion_busy_flag)
        short_run <= byte_address_line;
      busy_cnt <= conversion_busy_flag ? busy_cnt + 1 : 0;
    end
  end

  // ==========================================================
  // Properties
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_start;
    conv_req && !conv_req_q && !conversion_busy_flag;
  endsequence
  sequence s_opened;
    conversion_busy_flag && !short_cycle_done && !full_cycle_done;
  endsequence
  sequence s_read;
    chip_en && !sel_n && read_conv && !conversion_busy_flag;
  endsequence

  a_start_opens: assert property (s_start |=> s_opened)
    else $error("start did not open a cycle");
  a_idle_quiet: assert property (
    (!chip_en || sel_n) && !conversion_busy_flag
    |=> !conversion_busy_flag && !data_hi_oe)
    else $error("activity while not selected");
  a_busy_no_oe: assert property (
    conversion_busy_flag |-> !data_hi_oe && !data_lo_oe)
    else $error("data driven during conversion");
  a_read_drives: assert property (s_read |=> data_hi_oe)
    else $error("read did not drive data");
  a_width_lanes: assert property (
    data_hi_oe |-> data_lo_oe == word_width_sel)
    else $error("wrong lanes for width");
  a_odd_nibble: assert property (
    data_hi_oe && !word_width_sel &&
    $past(byte_address_line) |-> data[7:4] == 4'h0)
    else $error("odd byte low nibble not zero");
  // Busy flag is registered, so it drops one cycle after the last step
  a_cycle_len: assert property (
    $fell(conversion_busy_flag) |-> busy_cnt == need + 1)
    else $error("conversion length wrong");
  a_end_flags: assert property (
    $fell(conversion_busy_flag) |-> full_cycle_done && short_cycle_done)
    else $error("done flags low at cycle end");
  a_short_mid: assert property (
    $rose(short_cycle_done)
    |-> busy_cnt >= SHORT_CYC - 1 && busy_cnt <= SHORT_CYC)
    else $error("short flag at wrong time");
endmodule

`default_nettype wire

// File: testbench/sar_adc_bus_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "sarc_consts.svh"

module sar_adc_bus_control_tb;
  import sarc_pkg::*;
  typedef struct {sarc_word_t ain; logic short; logic word; sarc_word_t res;}
    sarc_row_t;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq_o;
  logic cmp_le;
  logic short_done;
  logic full_done;
  logic a0_q = 1'b0;
  logic err_seen;
  logic [31:0] rd;
  sarc_word_t trial_code;
  sarc_word_t ain = 12'h000;
  sarc_word_t exp_res = 12'h000;
  int n_errors = 0;
  int checks_done = 0;
  sarc_row_t rows[5] = '{'{12'hA5C, 0, 1, 12'hA5C}, '{12'h3F7, 0, 0, 12'h3F7},
    '{12'hFFF, 1, 1, 12'hFF0}, '{12'h001, 1, 0, 12'h000},
    '{12'h800, 0, 1, 12'h800}};

  initial forever #5 clk_i = ~clk_i;

  // ==========================================================
  // Two ends and checker
  sarc_bus_if bus_if ();
  sarc_host sarc_host_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_o(irq_o), .bus(bus_if));
  sarc_dev #(.BIT_STEP_CYC(2)) sarc_dev_inst (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .ce_i(1'b1), .bus(bus_if), .cmp_le_i(cmp_le),
    .trial_code_o(trial_code), .short_cycle_done_o(short_done),
    .full_cycle_done_o(full_done));
  assign cmp_le = trial_code <= ain;
  sarc_bus_asserts #(.BIT_STEP_CYC(2)) sarc_bus_asserts_inst (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .chip_en(bus_if.chip_en), .sel_n(bus_if.sel_n),
    .read_conv(bus_if.read_conv), .data(bus_if.data),
    .byte_address_line(bus_if.byte_address_line),
    .word_width_sel(bus_if.word_width_sel), .data_hi_oe(bus_if.data_hi_oe),
    .data_lo_oe(bus_if.data_lo_oe), .short_cycle_done(short_done),
    .conversion_busy_flag(bus_if.conversion_busy_flag),
    .full_cycle_done(full_done));

  // ==========================================================
  // Tasks
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1) @(posedge clk_i);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wait_idle;
    for (int i = 0; i < 400; i++)
    begin
      apb(1'b0, `SARC_OFS_STAT, 32'h0);
      if (rd[1:0] === 2'b00) break;
    end
    chk("idle wait", 0, rd[1:0]);
  endtask

  task run_row(input sarc_row_t r);
    ain <= r.ain;
    exp_res <= r.res;
    apb(1'b1, `SARC_OFS_CFG, {31'h0, r.word});
    apb(1'b1, `SARC_OFS_CMD, {30'h0, r.short, 1'b1});
    wait_idle();
    chk("conv irq", 1, irq_o);
    apb(1'b0, `SARC_OFS_IRQ_STAT, 32'h0);
    chk("conv status", 1, rd);
    apb(1'b1, `SARC_OFS_IRQ_STAT, 32'h3);
    apb(1'b1, `SARC_OFS_CMD, 32'h4);
    wait_idle();
    apb(1'b0, `SARC_OFS_IRQ_STAT, 32'h0);
    chk("read status", 2, rd);
    apb(1'b1, `SARC_OFS_IRQ_STAT, 32'h3);
    apb(1'b0, `SARC_OFS_RESULT, 32'h0);
    chk("result", {20'h0, r.res}, rd);
    chk("irq cleared", 0, irq_o);
  endtask

  task complete_run;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ==========================================================
  // Data lanes seen on the bus
  always @(posedge clk_i)
  begin
    a0_q <= bus_if.byte_address_line;
    if (rst_n_i && bus_if.data_hi_oe === 1'b1)
    begin
      if (bus_if.word_width_sel)
        chk("word lanes", exp_res, bus_if.data);
      else if (a0_q)
        chk("odd byte", {exp_res[3:0], 4'h0}, bus_if.data[11:4]);
      else
        chk("even byte", exp_res[11:4], bus_if.data[11:4]);
    end
  end

  initial
  begin
    repeat (30000) @(posedge clk_i);
    n_errors++;
    $display("ERROR watchdog expected finish seen timeout");
    complete_run();
  end

  // ==========================================================
  // Sequence
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    chk("busy at reset", 0, bus_if.conversion_busy_flag);
    chk("done at reset", 3, {short_done, full_done});
    apb(1'b0, `SARC_OFS_CFG, 32'h0);
    chk("cfg reset", 1, rd);
    apb(1'b0, `SARC_OFS_IRQ_MASK, 32'h0);
    chk("mask reset", 0, rd);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped error", 1, err_seen);
    $display("reset test done");
    apb(1'b1, `SARC_OFS_IRQ_MASK, 32'h3);
    foreach (rows[i])
    begin
      run_row(rows[i]);
      $display("row %0d done", i);
    end
    apb(1'b1, `SARC_OFS_IRQ_MASK, 32'h0);
    apb(1'b1, `SARC_OFS_CMD, 32'h1);
    apb(1'b1, `SARC_OFS_CFG, 32'h0);
    wait_idle();
    chk("masked irq", 0, irq_o);
    apb(1'b0, `SARC_OFS_IRQ_STAT, 32'h0);
    chk("masked status", 1, rd);
    apb(1'b0, `SARC_OFS_CFG, 32'h0);
    chk("cfg kept", 1, rd);
    $display("mask test done");
    apb(1'b1, `SARC_OFS_CMD, 32'h1);
    for (int i = 0; i < 200; i++)
    begin
      if (bus_if.conversion_busy_flag === 1'b1) break;
      @(posedge clk_i);
    end
    chk("busy seen", 1, bus_if.conversion_busy_flag);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("busy after abort", 0, bus_if.conversion_busy_flag);
    chk("done after abort", 3, {short_done, full_done});
    rst_n_i <= 1'b1;
    apb(1'b1, `SARC_OFS_IRQ_MASK, 32'h3);
    run_row('{12'h5A5, 0, 1, 12'h5A5});
    $display("abort test done");
    complete_run();
  end
endmodule

`default_nettype wire
